// *** verilog/lab_top.sv ***
`include "lab_defines.svh"
// What this block does
// - Setting auto-baud enable starts calibration; receiver held idle throughout
// - Measure a 55h sync, counting from the first rise after start
// - Divider pair counts up on the auto-baud clock until measurement ends
// - Fifth rise: keep count, clear auto-baud enable, set receive flag
// - Both divider bytes form one 16-bit counter at base clock / 8
// - Auto-baud clock is osc/32, osc/128 or osc/512 by the two selects
// - Counter starts at one; software subtracts one afterwards
// - On overflow set flag, keep counting, finish at the fifth rise
// - Overflow clear is refused while auto-baud enable is still set
// - With wake and auto-baud both set, measure the byte after break
// - While wake enable is set normal reception is off and receiver idles
// - Falling receive line is the wake event and sets the receive flag
// - Rising edge ending the break clears wake enable automatically
// - Nonzero character: low time to first rise is the wake event
// - Break frame is start bit, twelve zero bits, then stop bit
// - Data write with send-break and transmit enable starts a break
// - Clear send-break after break stop bit, then send queued byte
module lab_top
  import lab_pkg::*;
#(
  parameter int TXQ_DEPTH = `LAB_TXQ_DEPTH
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Serial pins
  input  wire logic        rx_line_in,
  output wire logic        tx_line_out,
  // Control bit strobes
  input  wire logic        autobaud_enable_set_in,
  input  wire logic        autobaud_enable_clr_in,
  input  wire logic        autobaud_overflow_clr_in,
  input  wire logic        wake_on_break_enable_set_in,
  input  wire logic        wake_on_break_enable_clr_in,
  input  wire logic        send_break_request_set_in,
  // Configuration levels
  input  wire logic        transmit_enable_in,
  input  wire logic        divider_16bit_select_in,
  input  wire logic        high_speed_select_in,
  // Divider write
  input  wire logic        divider_write_in,
  input  wire logic [15:0] divider_wdata_in,
  // Transmit data
  input  wire logic        transmit_data_write_in,
  input  wire logic [7:0]  transmit_data_in,
  output wire logic        transmit_ready_out,
  // Receive data
  input  wire logic        receive_data_read_in,
  output wire logic [7:0]  receive_data_out,
  // Status
  output wire logic        autobaud_enable_out,
  output wire logic        autobaud_overflow_flag_out,
  output wire logic        wake_on_break_enable_out,
  output wire logic        send_break_request_out,
  output wire logic        receive_flag_out,
  output wire logic        framing_error_flag_out,
  output wire logic        receiver_idle_status_out,
  output wire logic [15:0] divider_out
);

  lab_state_s s_ff;
  lab_state_s nxt_s;
  logic       brk_mark;

  lab_stream_if #(.W(`LAB_DATA_W + 1)) txq_if ();

  lab_txq #(
    .W (`LAB_DATA_W + 1),
    .D (TXQ_DEPTH)
  ) u_txq (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .q          (txq_if.store)
  );

  function automatic logic lab_pre_tick(input logic [8:0] pre,
                                        input logic b16,
                                        input logic hs,
                                        input logic ab);
    logic [3:0] sh;
    logic [8:0] mask;
    sh = (b16 & hs) ? `LAB_BASE_SH_FAST :
         (b16 | hs) ? `LAB_BASE_SH_MID : `LAB_BASE_SH_SLOW;
    if (ab) begin
      sh = sh + `LAB_ABD_EXTRA_SH;
    end
    mask = 9'((10'h001 << sh) - 10'h001);
    return (pre & mask) == mask;
  endfunction : lab_pre_tick

  // Bit time in base ticks minus one; 8-bit mode ignores the high byte
  function automatic logic [15:0] lab_bit_len(input logic [15:0] div,
                                              input logic b16);
    return b16 ? div : {8'h00, div[7:0]};
  endfunction : lab_bit_len

  // break marking
  // Only the first write after send-break is armed becomes the break; a
  // following write (the sync byte) is queued as ordinary data.
  assign brk_mark = s_ff.send_break_request & transmit_enable_in & ~s_ff.brk_pend;
  assign txq_if.push_valid = transmit_data_write_in;
  assign txq_if.push_data  = {brk_mark, transmit_data_in};
  assign txq_if.pop_ready  = (s_ff.tx == TX_IDLE) & transmit_enable_in;

  always_comb begin
    logic        fall;
    logic        rise;
    logic        base_tk;
    logic        abd_tk;
    logic        hold;
    logic        carry;
    logic [15:0] blen;
    fall    = 1'b0;
    rise    = 1'b0;
    base_tk = 1'b0;
    abd_tk  = 1'b0;
    hold    = 1'b0;
    carry   = 1'b0;
    blen    = '0;
    nxt_s   = s_ff;

    nxt_s.pre   = s_ff.pre + 9'h001;
    nxt_s.rx_s1 = rx_line_in;
    nxt_s.rx_s2 = s_ff.rx_s1;
    nxt_s.rx_d  = s_ff.rx_s2;
    fall    = s_ff.rx_d & ~s_ff.rx_s2;
    rise    = ~s_ff.rx_d & s_ff.rx_s2;
    base_tk = lab_pre_tick(s_ff.pre, divider_16bit_select_in,
                           high_speed_select_in, 1'b0);
    abd_tk  = lab_pre_tick(s_ff.pre, divider_16bit_select_in,
                           high_speed_select_in, 1'b1);
    blen    = lab_bit_len(s_ff.div, divider_16bit_select_in);

    // Software clears come first so that hardware sets below win
    if (autobaud_enable_clr_in) begin
      nxt_s.abd_en = 1'b0;
    end
    if (autobaud_enable_set_in) begin
      nxt_s.abd_en = 1'b1;
    end
    if (autobaud_overflow_clr_in && !s_ff.abd_en) begin
      nxt_s.abd_ovf = 1'b0;
    end
    if (wake_on_break_enable_clr_in) begin
      nxt_s.wk_en = 1'b0;
    end
    if (wake_on_break_enable_set_in) begin
      nxt_s.wk_en = 1'b1;
    end
    if (receive_data_read_in) begin
      nxt_s.rx_flag = 1'b0;
    end
    // A measurement in progress owns the divider
    if (divider_write_in && !s_ff.abd_en) begin
      nxt_s.div = divider_wdata_in;
    end

    if (s_ff.wk_en) begin
      if (fall) begin
        nxt_s.rx_flag = 1'b1;
      end
      if (rise) begin
        nxt_s.wk_en = 1'b0;
      end
    end

    if (!s_ff.abd_en) begin
      nxt_s.ab = AB_OFF;
    end else begin
      unique case (s_ff.ab)
        AB_OFF: begin
          if (!s_ff.wk_en) begin
            nxt_s.ab = AB_START;
          end
        end
        AB_START: begin
          if (fall) begin
            nxt_s.ab = AB_FIRST;
          end
        end
        AB_FIRST: begin
          if (rise) begin
            nxt_s.div   = `LAB_ABD_START_CNT;
            nxt_s.rises = '0;
            nxt_s.ab    = AB_RUN;
          end
        end
        AB_RUN: begin
          if (abd_tk) begin
            {carry, nxt_s.div} = 17'(s_ff.div) + 17'h00001;
            if (carry) begin
              nxt_s.abd_ovf = 1'b1;
            end
          end
          if (rise) begin
            if (s_ff.rises == `LAB_ABD_LAST_RISE) begin
              nxt_s.abd_en  = 1'b0;
              nxt_s.rx_flag = 1'b1;
              nxt_s.ab      = AB_OFF;
            end else begin
              nxt_s.rises = s_ff.rises + 3'h1;
            end
          end
        end
      endcase
    end

    hold = s_ff.abd_en | s_ff.wk_en;
    if (hold) begin
      nxt_s.rx = RX_IDLE;
    end else begin
      unique case (s_ff.rx)
        RX_IDLE: begin
          if (fall) begin
            nxt_s.rx     = RX_BITS;
            nxt_s.rx_tmr = blen >> 1;
            nxt_s.rx_bit = '0;
          end
        end
        RX_BITS: begin
          if (base_tk) begin
            if (s_ff.rx_tmr == '0) begin
              nxt_s.rx_tmr = blen;
              nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
              if (s_ff.rx_bit == 4'h0 && s_ff.rx_s2) begin
                // Glitch, not a start bit
                nxt_s.rx = RX_IDLE;
              end else if (s_ff.rx_bit == `LAB_RX_STOP_IDX) begin
                // break shows as zero data with framing error
                nxt_s.rx_data = s_ff.rx_sh;
                nxt_s.framing_error_flag    = ~s_ff.rx_s2;
                nxt_s.rx_flag = 1'b1;
                nxt_s.rx      = RX_IDLE;
              end else if (s_ff.rx_bit != 4'h0) begin
                nxt_s.rx_sh = {s_ff.rx_s2, s_ff.rx_sh[7:1]};
              end
            end else begin
              nxt_s.rx_tmr = s_ff.rx_tmr - 16'h0001;
            end
          end
        end
      endcase
    end
    nxt_s.rx_idle = (nxt_s.rx == RX_IDLE);

    unique case (s_ff.tx)
      TX_IDLE: begin
        nxt_s.tx_line = 1'b1;
        if (txq_if.pop_valid && txq_if.pop_ready) begin
          nxt_s.tx_brk = txq_if.pop_data[`LAB_DATA_W];
          if (txq_if.pop_data[`LAB_DATA_W]) begin
            nxt_s.tx_sh = `LAB_BRK_FRAME;
            nxt_s.tx_n  = `LAB_BRK_BITS;
          end else begin
            nxt_s.tx_sh = {5'h1f, txq_if.pop_data[7:0], 1'b0};
            nxt_s.tx_n  = `LAB_NORM_BITS;
          end
          nxt_s.tx_tmr  = blen;
          nxt_s.tx_line = 1'b0;
          nxt_s.tx      = TX_SEND;
        end
      end
      TX_SEND: begin
        if (base_tk) begin
          if (s_ff.tx_tmr == '0) begin
            nxt_s.tx_tmr = blen;
            nxt_s.tx_sh  = {1'b1, s_ff.tx_sh[13:1]};
            nxt_s.tx_n   = s_ff.tx_n - 4'h1;
            if (s_ff.tx_n == 4'h1) begin
              nxt_s.tx      = TX_IDLE;
              nxt_s.tx_line = 1'b1;
              if (s_ff.tx_brk) begin
                nxt_s.send_break_request    = 1'b0;
                nxt_s.brk_pend = 1'b0;
              end
            end else begin
              nxt_s.tx_line = s_ff.tx_sh[1];
            end
          end else begin
            nxt_s.tx_tmr = s_ff.tx_tmr - 16'h0001;
          end
        end
      end
    endcase

    if (brk_mark && transmit_data_write_in && txq_if.push_ready) begin
      nxt_s.brk_pend = 1'b1;
    end
    if (send_break_request_set_in) begin
      nxt_s.send_break_request = 1'b1;
    end
  end

  // Line synchronisers reset high so reset release is not seen as a fall
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_ff         <= '0;
      s_ff.rx_s1   <= 1'b1;
      s_ff.rx_s2   <= 1'b1;
      s_ff.rx_d    <= 1'b1;
      s_ff.rx_idle <= 1'b1;
      s_ff.tx_line <= 1'b1;
      s_ff.div     <= `LAB_DIV_RST;
      s_ff.ab      <= AB_OFF;
      s_ff.rx      <= RX_IDLE;
      s_ff.tx      <= TX_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tx_line_out                = s_ff.tx_line;
  assign transmit_ready_out         = txq_if.push_ready;
  assign receive_data_out           = s_ff.rx_data;
  assign autobaud_enable_out        = s_ff.abd_en;
  assign autobaud_overflow_flag_out = s_ff.abd_ovf;
  assign wake_on_break_enable_out   = s_ff.wk_en;
  assign send_break_request_out     = s_ff.send_break_request;
  assign receive_flag_out           = s_ff.rx_flag;
  assign framing_error_flag_out     = s_ff.framing_error_flag;
  assign receiver_idle_status_out   = s_ff.rx_idle;
  assign divider_out                = s_ff.div;
endmodule : lab_top

// *** inc/lab_defines.svh ***
`ifndef LAB_DEFINES_SVH
`define LAB_DEFINES_SVH
// Prescaler width covers the slowest auto-baud tick (osc / 512)
`define LAB_PRE_W        9
// Base clock shifts: osc/4, osc/16, osc/64
`define LAB_BASE_SH_FAST 4'h2
`define LAB_BASE_SH_MID  4'h4
`define LAB_BASE_SH_SLOW 4'h6
// Auto-baud clock is one eighth of the base clock
`define LAB_ABD_EXTRA_SH 4'h3
// Rising edges counted after the first one; the last is the fifth overall
`define LAB_ABD_LAST_RISE 3'h3
`define LAB_ABD_START_CNT 16'h0001
`define LAB_DIV_RST      16'h0000
// Frame lengths in bits, start and stop included
`define LAB_NORM_BITS    4'ha
`define LAB_BRK_BITS     4'he
`define LAB_RX_STOP_IDX  4'h9
`define LAB_BRK_FRAME    14'h2000
`define LAB_TXQ_DEPTH    16
`define LAB_DATA_W       8
`endif

// *** inc/lab_pkg.sv ***
package lab_pkg;
  typedef enum logic [1:0] {AB_OFF, AB_START, AB_FIRST, AB_RUN} lab_ab_e;
  typedef enum logic {RX_IDLE, RX_BITS} lab_rx_e;
  typedef enum logic {TX_IDLE, TX_SEND} lab_tx_e;

  typedef struct packed {
    logic [8:0]  pre;
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_d;
    logic        abd_en;
    logic        abd_ovf;
    logic        wk_en;
    logic        send_break_request;
    logic        brk_pend;
    logic        rx_flag;
    logic        framing_error_flag;
    logic [7:0]  rx_data;
    logic        rx_idle;
    logic [15:0] div;
    lab_ab_e     ab;
    logic [2:0]  rises;
    lab_rx_e     rx;
    logic [15:0] rx_tmr;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    lab_tx_e     tx;
    logic [15:0] tx_tmr;
    logic [3:0]  tx_n;
    logic [13:0] tx_sh;
    logic        tx_brk;
    logic        tx_line;
  } lab_state_s;
endpackage : lab_pkg

// *** inc/lab_stream_if.sv ***
interface lab_stream_if #(parameter int W = 9);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
  modport user  (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface : lab_stream_if

// *** verilog/lab_txq.sv ***
module lab_txq #(
  parameter int W = 9,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic    sys_clk_in,
  input wire logic    reset_n_in,
  // Queue ports
  lab_stream_if.store q
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         mcnt;
    logic                ov;
    logic [W-1:0]        od;
    logic                rdy;
  } lab_txq_s;

  lab_txq_s s_ff;
  lab_txq_s nxt_s;

  function automatic logic [AW-1:0] lab_ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : lab_ptr_inc

  // Head word sits in a register so the reader never sees the array directly
  always_comb begin
    logic        pop;
    logic        push;
    logic [AW:0] mc;
    pop   = 1'b0;
    push  = 1'b0;
    mc    = '0;
    nxt_s = s_ff;
    pop   = s_ff.ov & q.pop_ready;
    push  = q.push_valid & s_ff.rdy;
    mc    = s_ff.mcnt;
    if (push) begin
      nxt_s.mem[s_ff.wr] = q.push_data;
      nxt_s.wr           = lab_ptr_inc(s_ff.wr);
      mc                 = mc + (AW+1)'(1);
    end
    if ((!s_ff.ov || pop) && s_ff.mcnt != '0) begin
      nxt_s.od = s_ff.mem[s_ff.rd];
      nxt_s.rd = lab_ptr_inc(s_ff.rd);
      nxt_s.ov = 1'b1;
      mc       = mc - (AW+1)'(1);
    end else if (pop) begin
      nxt_s.ov = 1'b0;
    end
    nxt_s.mcnt = mc;
    // Ready registered so the full flag is a clean flop
    nxt_s.rdy  = (mc + (AW+1)'(nxt_s.ov)) < (AW+1)'(D);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_ff     <= '0;
      s_ff.rdy <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q.push_ready = s_ff.rdy;
  assign q.pop_valid  = s_ff.ov;
  assign q.pop_data   = s_ff.od;
endmodule : lab_txq

// *** verif/lab_top_chk.sv ***
module lab_top_chk (
  // Clock, reset and pins
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        rx_line_in,
  input wire logic        tx_line_out,
  // Control inputs
  input wire logic        autobaud_enable_clr_in,
  input wire logic        autobaud_overflow_clr_in,
  input wire logic        divider_16bit_select_in,
  input wire logic        high_speed_select_in,
  // Status outputs
  input wire logic        autobaud_enable_out,
  input wire logic        autobaud_overflow_flag_out,
  input wire logic        wake_on_break_enable_out,
  input wire logic        send_break_request_out,
  input wire logic        receive_flag_out,
  input wire logic        receiver_idle_status_out,
  input wire logic [15:0] divider_out
);
  logic [9:0]  gap_ff;
  logic [15:0] div_q_ff;
  logic [9:0]  tick_gap;
  logic        div_step;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Cycles since the divider last moved; the first tick after the start value has no fixed phase
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_ff   <= 10'h000;
      div_q_ff <= 16'h0000;
    end else begin
      gap_ff   <= (divider_out != div_q_ff) ? 10'h000 : gap_ff + 10'h001;
      div_q_ff <= divider_out;
    end
  end
  assign tick_gap = (divider_16bit_select_in && high_speed_select_in) ? 10'h01f :
                    (divider_16bit_select_in || high_speed_select_in) ? 10'h07f : 10'h1ff;
  assign div_step = autobaud_enable_out && (divider_out != div_q_ff);

  sequence s_pin_fall;
    wake_on_break_enable_out && $fell(rx_line_in);
  endsequence
  sequence s_pin_rise;
    wake_on_break_enable_out && $rose(rx_line_in);
  endsequence

  a_abd_idle_hold: assert property (autobaud_enable_out |-> receiver_idle_status_out)
    else $error("receiver busy during auto-baud");
  a_abd_done_flag: assert property (
    $fell(autobaud_enable_out) && !$past(autobaud_enable_clr_in) |-> receive_flag_out)
    else $error("auto-baud ended without receive flag");
  a_abd_count_step: assert property (
    div_step && divider_out != 16'h0001 |-> divider_out == div_q_ff + 16'h0001)
    else $error("auto-baud count step not one");
  a_abd_tick_rate: assert property (
    div_step && divider_out > 16'h0002 |-> gap_ff == tick_gap)
    else $error("auto-baud tick spacing wrong");
  a_ovf_clear_refused: assert property (
    autobaud_enable_out && autobaud_overflow_flag_out |=> autobaud_overflow_flag_out)
    else $error("overflow flag lost while enabled");
  a_ovf_clear_taken: assert property (
    !autobaud_enable_out && autobaud_overflow_clr_in |=> !autobaud_overflow_flag_out)
    else $error("overflow flag not cleared");
  a_wake_idle_hold: assert property (
    wake_on_break_enable_out |-> receiver_idle_status_out)
    else $error("receiver busy during wake watch");
  a_wake_fall_flag: assert property (s_pin_fall |-> ##3 receive_flag_out)
    else $error("wake fall did not set receive flag");
  a_wake_rise_clear: assert property (s_pin_rise |-> ##3 !wake_on_break_enable_out)
    else $error("wake enable not cleared by rise");
  a_brk_stop_high: assert property ($fell(send_break_request_out) |-> $past(tx_line_out))
    else $error("send-break cleared before stop bit");
endmodule : lab_top_chk

bind lab_top lab_top_chk lab_top_chk_inst (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .rx_line_in(rx_line_in),
  .tx_line_out(tx_line_out), .autobaud_enable_clr_in(autobaud_enable_clr_in),
  .autobaud_overflow_clr_in(autobaud_overflow_clr_in),
  .divider_16bit_select_in(divider_16bit_select_in), .high_speed_select_in(high_speed_select_in),
  .autobaud_enable_out(autobaud_enable_out),
  .autobaud_overflow_flag_out(autobaud_overflow_flag_out),
  .wake_on_break_enable_out(wake_on_break_enable_out),
  .send_break_request_out(send_break_request_out), .receive_flag_out(receive_flag_out),
  .receiver_idle_status_out(receiver_idle_status_out), .divider_out(divider_out));

// *** verif/lab_node.sv ***
module lab_node (
  // Clock
  input  wire logic sys_clk_in,
  // Serial lines
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Line idles high as with its pull-up
  initial rx_line_out = 1'b1;
  task automatic send(input logic [15:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      rx_line_out <= bits[i];
      repeat (per - 1) @(posedge sys_clk_in);
    end
  endtask : send
  // Returns at mid stop bit so the next start edge is not missed
  task automatic get(input int n, input int per, output logic [15:0] bits);
    bits = 16'h0000;
    @(posedge sys_clk_in);
    while (tx_line_in !== 1'b0) @(posedge sys_clk_in);
    repeat (per / 2) @(posedge sys_clk_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_line_in;
      if (i < n - 1) repeat (per) @(posedge sys_clk_in);
    end
  endtask : get
endmodule : lab_node

// *** verif/lab_top_test.sv ***
module lab_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in, reset_n_in, tx_en, b16, hs, tx_wr;
  logic [7:0]  strb, tx_dat;
  logic [15:0] wdat, v, w;
  wire logic   rx_line, tx_line, tx_rdy, abd, ovf, wake, send_break_request, rflag, framing_error_flag, ridle;
  wire logic [7:0]  rx_dat;
  wire logic [15:0] div;
  int          num_errors, checked;
  int          tk[4] = '{512, 128, 128, 32};

  lab_top #(.TXQ_DEPTH(16)) lab_top_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .rx_line_in(rx_line),
    .tx_line_out(tx_line), .autobaud_enable_set_in(strb[0]), .autobaud_enable_clr_in(strb[1]),
    .autobaud_overflow_clr_in(strb[2]), .wake_on_break_enable_set_in(strb[3]),
    .wake_on_break_enable_clr_in(strb[4]), .send_break_request_set_in(strb[5]),
    .transmit_enable_in(tx_en), .divider_16bit_select_in(b16), .high_speed_select_in(hs),
    .divider_write_in(strb[7]), .divider_wdata_in(wdat), .transmit_data_write_in(tx_wr),
    .transmit_data_in(tx_dat), .transmit_ready_out(tx_rdy), .receive_data_read_in(strb[6]),
    .receive_data_out(rx_dat), .autobaud_enable_out(abd), .autobaud_overflow_flag_out(ovf),
    .wake_on_break_enable_out(wake), .send_break_request_out(send_break_request),
    .receive_flag_out(rflag), .framing_error_flag_out(framing_error_flag),
    .receiver_idle_status_out(ridle), .divider_out(div));
  lab_node lab_node_inst (.sys_clk_in(sys_clk_in), .tx_line_in(tx_line), .rx_line_out(rx_line));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h want %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t count %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Strobe bits: 0 abd set, 1 abd clr, 2 ovf clr, 3 wake set, 4 wake clr, 5 break, 6 read, 7 div
  task automatic pulse(input int k);
    @(posedge sys_clk_in);
    strb <= 8'h01 << k;
    @(posedge sys_clk_in);
    strb <= 8'h00;
    @(posedge sys_clk_in);
  endtask : pulse
  task automatic tx_write(input logic [7:0] d);
    @(posedge sys_clk_in);
    tx_wr  <= 1'b1;
    tx_dat <= d;
    @(posedge sys_clk_in);
    while (tx_rdy !== 1'b1) @(posedge sys_clk_in);
    tx_wr <= 1'b0;
  endtask : tx_write
  // Sync byte at five ticks a bit: forty ticks between first and fifth rise, plus start value
  task automatic sync_check(input int tick);
    lab_node_inst.send(16'hfeaa, 10, tick * 5);
    chk1(abd, 1'b0);
    chk1(rflag, 1'b1);
    chk_rng(div, 16'h0029, 16'h002a);
    pulse(6);
    chk1(rflag, 1'b0);
  endtask : sync_check

  initial begin
    {reset_n_in, tx_en, tx_wr, strb, tx_dat} = '0;
    {b16, hs} = 2'b11;
    wdat = 16'h0009;
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    pulse(0);
    pulse(1);
    chk1(abd, 1'b0);
    pulse(2);
    chk1(ovf, 1'b0);
    for (int m = 0; m < 4; m++) begin
      {b16, hs} <= m[1:0];
      pulse(0);
      chk1(ridle, 1'b1);
      sync_check(tk[m]);
    end
    chk1(ridle, 1'b1);
    pulse(3);
    pulse(0);
    lab_node_inst.send(16'h2000, 14, 160);
    chk1(wake, 1'b0);
    chk1(rflag, 1'b1);
    chk1(abd, 1'b1);
    pulse(6);
    sync_check(32);
    pulse(3);
    lab_node_inst.send(16'hff4a, 10, 160);
    chk1(wake, 1'b0);
    chk1(rflag, 1'b1);
    repeat (2000) @(posedge sys_clk_in);
    pulse(6);
    pulse(7);
    lab_node_inst.send(16'h2000, 14, 40);
    chk1(rflag, 1'b1);
    chk1(framing_error_flag, 1'b1);
    chk16({8'h00, rx_dat}, 16'h0000);
    pulse(6);
    lab_node_inst.send(16'hff4a, 10, 40);
    chk1(framing_error_flag, 1'b0);
    chk16({8'h00, rx_dat}, 16'h00a5);
    pulse(6);
    tx_en <= 1'b1;
    pulse(5);
    chk1(send_break_request, 1'b1);
    fork
      begin
        lab_node_inst.get(14, 40, v);
        lab_node_inst.get(10, 40, w);
      end
      begin
        tx_write(8'hff);
        tx_write(8'h55);
      end
    join
    chk16(v, 16'h2000);
    chk16(w, 16'h02aa);
    chk1(send_break_request, 1'b0);
    @(posedge sys_clk_in);
    tx_en <= 1'b0;
    for (int i = 1; i <= 16; i++) tx_write(8'(i));
    repeat (3) @(posedge sys_clk_in);
    chk1(tx_rdy, 1'b0);
    tx_wr  <= 1'b1;
    tx_dat <= 8'h99;
    @(posedge sys_clk_in);
    tx_wr <= 1'b0;
    tx_en <= 1'b1;
    for (int i = 1; i <= 16; i++) begin
      lab_node_inst.get(10, 40, w);
      chk16(w, {6'h00, 1'b1, 8'(i), 1'b0});
    end
    // A refused word would start its frame here, just after the last stop bit
    repeat (30) @(posedge sys_clk_in);
    chk1(tx_line, 1'b1);
    repeat (370) @(posedge sys_clk_in);
    chk1(tx_rdy, 1'b1);
    wrap_up();
  end

  // Normal run is near 60k cycles
  initial begin
    #(25 * 95000);
    num_errors++;
    wrap_up();
  end
endmodule : lab_top_test
